// file: core/gpio_port.sv
// gpio port with per-pin direction, mask operations and pin interrupts
`timescale 1ns/1ps
module gpio_port (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // register bus
    input wire gpio_pkg::avmm_req_t avs_i,
    output logic [gpio_pkg::DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // pins
    input wire logic [gpio_pkg::NPINS-1:0] pin_i,
    output logic [gpio_pkg::NPINS-1:0] pin_o,
    output logic [gpio_pkg::NPINS-1:0] pin_oe_o,
    // interrupt request
    output logic irq_o
);
    localparam int N = gpio_pkg::NPINS;
    localparam int DW = gpio_pkg::DW;

    logic [DW-1:0] data_out;
    logic [N-1:0] dir;
    logic [N-1:0] sync_meta;
    logic [N-1:0] sync_pin;
    logic [N-1:0] prev_pin;
    logic [gpio_pkg::SENSE_W*N-1:0] sense;
    logic [N-1:0] both_edge;
    logic [N-1:0] sense_active;
    logic [N-1:0] int_enable;
    logic [N-1:0] int_status;
    logic [N-1:0] event_hit;
    logic [N-1:0] pin_view;
    logic [DW-1:0] be_mask;
    logic [DW-1:0] wd;
    logic [DW-1:0] next_readdata;
    logic [DW-1:0] next_data_out;
    logic wr_hit;
    logic rd_req;

    // bus: one wait cycle, then the request completes
    assign wr_hit = ce_i && avs_i.write && !avs_waitrequest_o;
    assign rd_req = avs_i.read && !avs_i.write;
    assign wd = avs_i.writedata & be_mask;

    always_comb begin
        for (int b = 0; b < gpio_pkg::BEW; b++) begin
            be_mask[8*b +: 8] = {8{avs_i.byteenable[b]}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= gpio_pkg::RESET_WORD;
        end else if (ce_i) begin
            if ((avs_i.read || avs_i.write) && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= rd_req ? next_readdata : gpio_pkg::RESET_WORD;
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    // reads of output pins return the driven level, input pins the sampled one
    assign pin_view = (dir & data_out) | (~dir & sync_pin);

    always_comb begin
        next_readdata = gpio_pkg::RESET_WORD;
        unique case (avs_i.address)
            gpio_pkg::OFF_DATA_OUT: next_readdata = data_out;
            gpio_pkg::OFF_DIR: next_readdata = dir;
            gpio_pkg::OFF_PIN_IN: next_readdata = pin_view;
            gpio_pkg::OFF_PAD_STATUS: next_readdata = sync_pin;
            gpio_pkg::OFF_SENSE_LO: next_readdata = sense[DW-1:0];
            gpio_pkg::OFF_SENSE_HI: next_readdata = sense[2*DW-1:DW];
            gpio_pkg::OFF_BOTH_EDGE: next_readdata = both_edge;
            gpio_pkg::OFF_SENSE_ACTIVE: next_readdata = sense_active;
            gpio_pkg::OFF_INT_ENABLE: next_readdata = int_enable;
            gpio_pkg::OFF_INT_STATUS: next_readdata = int_status;
            default: next_readdata = gpio_pkg::RESET_WORD;
        endcase
    end

    // output data register and mask operations
    always_comb begin
        next_data_out = data_out;
        if (wr_hit) begin
            unique case (avs_i.address)
                gpio_pkg::OFF_DATA_OUT: next_data_out = (data_out & ~be_mask) | wd;
                gpio_pkg::OFF_OUT_SET: next_data_out = data_out | wd;
                gpio_pkg::OFF_OUT_CLEAR: next_data_out = data_out & ~wd;
                gpio_pkg::OFF_OUT_TOGGLE: next_data_out = data_out ^ wd;
                default: next_data_out = data_out;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            data_out <= gpio_pkg::RESET_WORD;
        end else if (ce_i) begin
            data_out <= next_data_out;
        end
    end

    // pins drive only where the direction is output
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pin_o <= gpio_pkg::RESET_WORD;
            pin_oe_o <= gpio_pkg::RESET_WORD;
        end else if (ce_i) begin
            pin_o <= next_data_out;
            pin_oe_o <= (wr_hit && avs_i.address == gpio_pkg::OFF_DIR) ?
                ((dir & ~be_mask) | wd) : dir;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dir <= gpio_pkg::RESET_WORD;
            sense <= {2{gpio_pkg::RESET_WORD}};
            both_edge <= gpio_pkg::RESET_WORD;
            sense_active <= gpio_pkg::RESET_WORD;
        end else if (wr_hit) begin
            unique case (avs_i.address)
                gpio_pkg::OFF_DIR: dir <= (dir & ~be_mask) | wd;
                gpio_pkg::OFF_SENSE_LO: sense[DW-1:0] <= (sense[DW-1:0] & ~be_mask) | wd;
                gpio_pkg::OFF_SENSE_HI: sense[2*DW-1:DW] <= (sense[2*DW-1:DW] & ~be_mask) | wd;
                gpio_pkg::OFF_BOTH_EDGE: both_edge <= (both_edge & ~be_mask) | wd;
                gpio_pkg::OFF_SENSE_ACTIVE: sense_active <= (sense_active & ~be_mask) | wd;
                default: dir <= dir;
            endcase
        end
    end

    // interrupt enable through set and clear masks
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            int_enable <= gpio_pkg::RESET_WORD;
        end else if (wr_hit) begin
            unique case (avs_i.address)
                gpio_pkg::OFF_INT_ENABLE: int_enable <= (int_enable & ~be_mask) | wd;
                gpio_pkg::OFF_ENABLE_SET: int_enable <= int_enable | wd;
                gpio_pkg::OFF_ENABLE_CLEAR: int_enable <= int_enable & ~wd;
                default: int_enable <= int_enable;
            endcase
        end
    end

    // two-stage synchroniser, then a third stage for edge history
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync_meta <= gpio_pkg::RESET_WORD;
            sync_pin <= gpio_pkg::RESET_WORD;
            prev_pin <= gpio_pkg::RESET_WORD;
        end else if (ce_i) begin
            sync_meta <= pin_i;
            sync_pin <= sync_meta;
            prev_pin <= sync_pin;
        end
    end

    // per-pin event detection
    for (genvar p = 0; p < N; p++) begin : g_detect
        logic [gpio_pkg::SENSE_W-1:0] mode;
        logic rise;
        logic fall;
        assign mode = sense[gpio_pkg::SENSE_W*p +: gpio_pkg::SENSE_W];
        assign rise = sync_pin[p] && !prev_pin[p];
        assign fall = !sync_pin[p] && prev_pin[p];
        always_comb begin
            event_hit[p] = 1'b0;
            if (!sense_active[p]) begin
                event_hit[p] = 1'b0;
            end else if (both_edge[p]) begin
                event_hit[p] = rise || fall;
            end else begin
                unique case (mode)
                    gpio_pkg::LOW_LEVEL_SENSE_MODE: event_hit[p] = !sync_pin[p];
                    gpio_pkg::HIGH_LEVEL_SENSE_MODE: event_hit[p] = sync_pin[p];
                    gpio_pkg::RISING_EDGE_SENSE_MODE: event_hit[p] = rise;
                    gpio_pkg::FALLING_EDGE_SENSE_MODE: event_hit[p] = fall;
                endcase
            end
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            int_status <= gpio_pkg::RESET_WORD;
        end else if (ce_i) begin
            if (wr_hit && avs_i.address == gpio_pkg::OFF_INT_STATUS) begin
                int_status <= (int_status & ~wd) | event_hit;
            end else begin
                int_status <= int_status | event_hit;
            end
        end
    end

    // registered, so the request lags the flag by one cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(int_status & int_enable);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    logic past_valid;
    always_ff @(posedge clk_i) begin
        past_valid <= !srst_i;
    end

    a_single_write: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_DATA_OUT && avs_i.byteenable == 4'hF
        |=> pin_o == $past(avs_i.writedata))
        else $error("pin level differs from written value");
    a_mask_set: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_OUT_SET
        |=> pin_o == ($past(data_out) | $past(wd)))
        else $error("set mask result wrong");
    a_mask_clear: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_OUT_CLEAR
        |=> pin_o == ($past(data_out) & ~$past(wd)))
        else $error("clear mask result wrong");
    a_mask_toggle: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_OUT_TOGGLE
        |=> pin_o == ($past(data_out) ^ $past(wd)))
        else $error("toggle mask result wrong");
    a_pad_read: assert property (
        avs_i.read && avs_waitrequest_o && avs_i.address == gpio_pkg::OFF_PAD_STATUS
        |=> !avs_waitrequest_o && avs_readdata_o == $past(sync_pin))
        else $error("pad status read wrong or late");
    a_dir_drive: assert property (
        past_valid |-> pin_oe_o == dir)
        else $error("output enable does not follow direction");
    a_quiet_pin: assert property (
        (int_status & ~$past(int_status) & ~$past(sense_active)) == '0)
        else $error("flag set on pin without sensing");
    a_both_edges: assert property (
        ((sense_active & both_edge & (sync_pin ^ prev_pin)) & ~event_hit) == '0)
        else $error("edge missed in both-edges mode");
    a_enable_mask: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_ENABLE_CLEAR
        |=> (int_enable & $past(wd)) == '0)
        else $error("enable not cleared by mask");
    a_clear_ones: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_INT_STATUS
        |=> ((($past(int_status) & ~$past(wd)) & ~int_status) == '0)
            && ((int_status & $past(wd) & ~$past(event_hit)) == '0))
        else $error("status clear touched wrong bits");
    a_flag_irq: assert property (
        event_hit != '0 ##0 (event_hit & int_enable) != '0 ##1 ce_i |=> irq_o)
        else $error("enabled event did not raise irq in two cycles");

    // bus handshake: idle high, exactly one wait state per request; then status, input and unmapped read data checks
    a_wait_idle: assert property (
        !(avs_i.read || avs_i.write)
        |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    a_wait_accept: assert property (
        (avs_i.read || avs_i.write) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("request not answered after one wait state");
    a_wait_single: assert property (
        !avs_waitrequest_o
        |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_status_read: assert property (
        avs_i.read && avs_waitrequest_o && avs_i.address == gpio_pkg::OFF_INT_STATUS
        |=> avs_readdata_o == $past(int_status))
        else $error("status word read wrong");
    a_input_read: assert property (
        avs_i.read && avs_waitrequest_o && avs_i.address == gpio_pkg::OFF_PIN_IN
        |=> (avs_readdata_o & ~$past(dir)) == ($past(sync_pin) & ~$past(dir)))
        else $error("input pin level read wrong");
    a_unmapped_read: assert property (
        avs_i.read && avs_waitrequest_o && avs_i.address > gpio_pkg::OFF_ENABLE_CLEAR
        |=> avs_readdata_o == '0)
        else $error("unmapped address read not zero");

    // register, pin, synchroniser and irq checks
    a_enable_set: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_ENABLE_SET
        |=> (int_enable & $past(wd)) == $past(wd))
        else $error("enable not set by mask");
    a_enable_hold: assert property (
        !wr_hit
        |=> int_enable == $past(int_enable))
        else $error("enable changed without a write");
    a_pin_hold: assert property (
        !wr_hit
        |=> pin_o == $past(pin_o))
        else $error("pin level changed without a write");
    a_dir_write: assert property (
        wr_hit && avs_i.address == gpio_pkg::OFF_DIR && avs_i.byteenable == 4'hF
        |=> pin_oe_o == $past(avs_i.writedata))
        else $error("output enable differs from written direction");
    a_sync_delay: assert property (
        ce_i ##1 ce_i
        |=> sync_pin == $past(pin_i, 2))
        else $error("synchronised pin not two cycles behind pad");
    a_edge_history: assert property (
        ce_i
        |=> prev_pin == $past(sync_pin))
        else $error("edge history stage out of step");
    a_irq_quiet: assert property (
        (int_status & int_enable) == '0
        |=> !irq_o)
        else $error("irq raised with no enabled flag");

    // per-pin sense checks: the selected condition must leave its flag set
    for (genvar p = 0; p < N; p++) begin : g_sense_chk
        logic plain;
        assign plain = sense_active[p] && !both_edge[p];
        a_low_flag: assert property (
            plain && g_detect[p].mode == gpio_pkg::LOW_LEVEL_SENSE_MODE && !sync_pin[p]
            |=> int_status[p])
            else $error("low level did not set its flag");
        a_high_flag: assert property (
            plain && g_detect[p].mode == gpio_pkg::HIGH_LEVEL_SENSE_MODE && sync_pin[p]
            |=> int_status[p])
            else $error("high level did not set its flag");
        a_rise_flag: assert property (
            plain && g_detect[p].mode == gpio_pkg::RISING_EDGE_SENSE_MODE
            && sync_pin[p] && !prev_pin[p]
            |=> int_status[p])
            else $error("rising edge did not set its flag");
        a_fall_flag: assert property (
            plain && g_detect[p].mode == gpio_pkg::FALLING_EDGE_SENSE_MODE
            && !sync_pin[p] && prev_pin[p]
            |=> int_status[p])
            else $error("falling edge did not set its flag");
        a_both_flag: assert property (
            sense_active[p] && both_edge[p] && (sync_pin[p] != prev_pin[p])
            |=> int_status[p])
            else $error("edge in both-edges mode did not set its flag");
    end

    c_set_op: cover property (wr_hit && avs_i.address == gpio_pkg::OFF_OUT_SET);
    c_edge_irq: cover property ((event_hit & both_edge) != '0 ##2 irq_o);
    c_clear_race: cover property (wr_hit && avs_i.address == gpio_pkg::OFF_INT_STATUS
        && (event_hit & wd) != '0);
    c_dir_write: cover property (wr_hit && avs_i.address == gpio_pkg::OFF_DIR);
    c_level_flag: cover property ((sense_active & ~both_edge & int_status) != '0);
endmodule

// file: common/gpio_pkg.sv
// constants, types and register map of the pin-interrupt gpio port
package gpio_pkg;
    localparam int NPINS = 32;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int BEW = 4;
    localparam int SENSE_W = 2;
    localparam int HALF = 16;

    // byte addresses of the register words
    localparam logic [AW-1:0] OFF_DATA_OUT = 8'h00;
    localparam logic [AW-1:0] OFF_DIR = 8'h04;
    localparam logic [AW-1:0] OFF_PIN_IN = 8'h08;
    localparam logic [AW-1:0] OFF_PAD_STATUS = 8'h0C;
    localparam logic [AW-1:0] OFF_SENSE_LO = 8'h10;
    localparam logic [AW-1:0] OFF_SENSE_HI = 8'h14;
    localparam logic [AW-1:0] OFF_BOTH_EDGE = 8'h18;
    localparam logic [AW-1:0] OFF_SENSE_ACTIVE = 8'h1C;
    localparam logic [AW-1:0] OFF_INT_ENABLE = 8'h20;
    localparam logic [AW-1:0] OFF_INT_STATUS = 8'h24;
    localparam logic [AW-1:0] OFF_OUT_SET = 8'h28;
    localparam logic [AW-1:0] OFF_OUT_CLEAR = 8'h2C;
    localparam logic [AW-1:0] OFF_OUT_TOGGLE = 8'h30;
    localparam logic [AW-1:0] OFF_ENABLE_SET = 8'h34;
    localparam logic [AW-1:0] OFF_ENABLE_CLEAR = 8'h38;

    localparam logic [DW-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [DW-1:0] ALL_ONES = 32'hFFFF_FFFF;

    // interrupt_sense_config_field encodings
    localparam logic [SENSE_W-1:0] LOW_LEVEL_SENSE_MODE = 2'h0;
    localparam logic [SENSE_W-1:0] HIGH_LEVEL_SENSE_MODE = 2'h1;
    localparam logic [SENSE_W-1:0] RISING_EDGE_SENSE_MODE = 2'h2;
    localparam logic [SENSE_W-1:0] FALLING_EDGE_SENSE_MODE = 2'h3;

    // pin direction bit values
    localparam logic PIN_DIR_INPUT = 1'b0;
    localparam logic PIN_DIR_OUTPUT = 1'b1;

    typedef struct packed {
        logic read;
        logic write;
        logic [AW-1:0] address;
        logic [DW-1:0] writedata;
        logic [BEW-1:0] byteenable;
    } avmm_req_t;
endpackage

// file: tb/pad_model.sv
// pad model: resolves each pin from the port drive and the outside level
`timescale 1ns/1ps
module pad_model (
    // port side
    input wire logic [gpio_pkg::NPINS-1:0] port_level_i,
    input wire logic [gpio_pkg::NPINS-1:0] port_oe_i,
    // outside world
    input wire logic [gpio_pkg::NPINS-1:0] ext_level_i,
    output logic [gpio_pkg::NPINS-1:0] pad_o
);
    // a driven pin shows the port level; an undriven one follows the outside source
    assign pad_o = (port_level_i & port_oe_i) | (ext_level_i & ~port_oe_i);
endmodule

// file: tb/gpio_port_bench.sv
// self-checking bench of the pin-interrupt gpio port
`timescale 1ns/1ps
module gpio_port_bench;
    typedef struct packed {
        logic wr;
        logic [gpio_pkg::AW-1:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic [31:0] p;
    } row_t;
    localparam row_t ROWS [15] = '{
        '{1'b1, gpio_pkg::OFF_DIR, 32'hFFFF_FFFF, '0, '0},
        '{1'b1, gpio_pkg::OFF_DATA_OUT, 32'h0000_0001, '0, 32'h0000_0001},
        '{1'b1, gpio_pkg::OFF_DATA_OUT, '0, '0, '0},
        '{1'b1, gpio_pkg::OFF_OUT_SET, 32'h8000_00F0, '0, 32'h8000_00F0},
        '{1'b1, gpio_pkg::OFF_OUT_CLEAR, 32'h8000_0030, '0, 32'h0000_00C0},
        '{1'b1, gpio_pkg::OFF_OUT_TOGGLE, 32'h0000_0181, '0, 32'h0000_0141},
        '{1'b0, gpio_pkg::OFF_DATA_OUT, '0, 32'h0000_0141, 32'h0000_0141},
        '{1'b0, gpio_pkg::OFF_OUT_SET, '0, '0, 32'h0000_0141},
        '{1'b1, gpio_pkg::OFF_PIN_IN, 32'hFFFF_FFFF, '0, 32'h0000_0141},
        '{1'b0, gpio_pkg::OFF_PIN_IN, '0, 32'h0000_0141, 32'h0000_0141},
        '{1'b0, 8'h3C, '0, '0, 32'h0000_0141},
        '{1'b1, gpio_pkg::OFF_DIR, 32'h0000_FFFF, '0, 32'h0000_0141},
        '{1'b1, gpio_pkg::OFF_DATA_OUT, 32'hFFFF_0000, '0, '0},
        '{1'b0, gpio_pkg::OFF_DATA_OUT, '0, 32'hFFFF_0000, '0},
        '{1'b1, gpio_pkg::OFF_DIR, 32'hFFFF_FFFF, '0, 32'hFFFF_0000}
    };
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce = 1'b1;
    gpio_pkg::avmm_req_t avs_i = '0;
    logic [31:0] avs_readdata_o;
    logic [31:0] pin_i;
    logic [31:0] pin_o;
    logic [31:0] pin_oe_o;
    logic [31:0] ext_level = '0;
    logic [31:0] q;
    logic avs_waitrequest_o;
    logic irq_o;
    int miscompares = 0;
    int check_count = 0;

    always #20 clk_i = ~clk_i;

    gpio_port u_gpio_port (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce),
        .avs_i(avs_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe_o(pin_oe_o),
        .irq_o(irq_o)
    );
    pad_model u_pad_model (
        .port_level_i(pin_o),
        .port_oe_i(pin_oe_o),
        .ext_level_i(ext_level),
        .pad_o(pin_i)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // request held through the rising edge at which waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        avs_i <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20) begin
            miscompares++;
            close_out();
        end
        q = avs_readdata_o;
        avs_i <= '0;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, '0);
        chk("read word", e, q);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        chk("oe after reset", '0, pin_oe_o);
        for (int a = 0; a <= 36; a += 4) begin
            rd(a[7:0], '0);
        end
        foreach (ROWS[i]) begin
            bus(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].wr) chk("row read", ROWS[i].q, q);
            settle(1);
            chk("driven pins", ROWS[i].p, pin_o & pin_oe_o);
        end
        bus(1'b1, gpio_pkg::OFF_DIR, '0);
        ext_level <= 32'h1234_5678;
        settle(4);
        rd(gpio_pkg::OFF_PIN_IN, 32'h1234_5678);
        rd(gpio_pkg::OFF_PAD_STATUS, 32'h1234_5678);
        // pins 0-3 low, high, rising, falling; pin 4 both edges; pin 5 inactive
        ext_level <= '0;
        bus(1'b1, gpio_pkg::OFF_SENSE_LO, 32'h0000_04E4);
        bus(1'b1, gpio_pkg::OFF_BOTH_EDGE, 32'h0000_0010);
        bus(1'b1, gpio_pkg::OFF_SENSE_ACTIVE, 32'h0000_001F);
        bus(1'b1, gpio_pkg::OFF_INT_STATUS, 32'hFFFF_FFFF);
        settle(4);
        rd(gpio_pkg::OFF_INT_STATUS, 32'h0000_0001);
        ext_level <= 32'h0000_003F;
        settle(5);
        rd(gpio_pkg::OFF_INT_STATUS, 32'h0000_0017);
        bus(1'b1, gpio_pkg::OFF_INT_STATUS, 32'h0000_0004);
        rd(gpio_pkg::OFF_INT_STATUS, 32'h0000_0013);
        bus(1'b1, gpio_pkg::OFF_INT_STATUS, 32'h0000_001F);
        rd(gpio_pkg::OFF_INT_STATUS, 32'h0000_0002);
        ext_level <= '0;
        settle(5);
        rd(gpio_pkg::OFF_INT_STATUS, 32'h0000_001B);
        chk("irq masked", '0, {31'b0, irq_o});
        bus(1'b1, gpio_pkg::OFF_ENABLE_SET, 32'h0000_0008);
        settle(2);
        chk("irq raised", 32'h0000_0001, {31'b0, irq_o});
        rd(gpio_pkg::OFF_INT_ENABLE, 32'h0000_0008);
        bus(1'b1, gpio_pkg::OFF_ENABLE_CLEAR, 32'h0000_0008);
        settle(2);
        chk("irq dropped", '0, {31'b0, irq_o});
        rd(gpio_pkg::OFF_INT_STATUS, 32'h0000_001B);
        // clock enable low: the synchroniser must not move
        ce <= 1'b0;
        ext_level <= 32'h0000_003F;
        repeat (4) @(posedge clk_i);
        ce <= 1'b1;
        rd(gpio_pkg::OFF_PAD_STATUS, '0);
        rd(gpio_pkg::OFF_PAD_STATUS, 32'h0000_003F);
        // reset in mid-run clears configuration, data and flags
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        chk("oe after mid reset", '0, pin_oe_o);
        chk("pins after mid reset", '0, pin_o);
        chk("irq after mid reset", '0, {31'b0, irq_o});
        rd(gpio_pkg::OFF_DATA_OUT, '0);
        rd(gpio_pkg::OFF_INT_STATUS, '0);
        close_out();
    end
endmodule
